/* logic/drive_control_mode_selector.sv */
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
module drive_control_mode_selector
  import drive_mode_pkg::*;
#(
  parameter int SPEED_W = 16
) (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic [N_TERM-1:0]   terminal_in,
  input  wire logic                second_function_pin,
  input  wire logic                drive_running,
  input  wire logic [SPEED_W-1:0]  output_freq,
  output ctrl_out_t                ctrl_out,
  output logic      [SPEED_W-1:0]  pulse_monitor_output,
  output logic      [SPEED_W-1:0]  analog_monitor_output
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [SET_W-1:0]                    control_method_code;
    logic [SET_W-1:0]                    motor_capacity_setting;
    logic [SET_W-1:0]                    pole_count_setting;
    logic [SET_W-1:0]                    second_motor_type_setting;
    logic [SET_W-1:0]                    second_control_method_code;
    logic [SET_W-1:0]                    second_motor_capacity_setting;
    logic [SET_W-1:0]                    second_motor_pole_setting;
    logic [SET_W-1:0]                    load_inertia_ratio_setting;
    logic [SET_W-1:0]                    low_speed_threshold_setting;
    logic [SPEED_W-1:0]                  speed_cmd;
    logic [N_TERM-1:0][FUNC_W-1:0]       input_terminal_function_settings;
    apply_state_t                        st;
    sel_t                                want;
    ctrl_out_t                           out;
    logic [SPEED_W-1:0]                  sim_speed;
    logic [SET_W-1:0]                    slope_cnt;
    logic [SPEED_W-1:0]                  mon;
    logic                                waitreq;
    logic [31:0]                         rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [SET_W-1:0] lanes(input logic [SET_W-1:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [SET_W-1:0] v;
    v = old;
    if (be[0]) v[7:0] = wd[7:0];
    if (be[1]) v[15:8] = wd[15:8];
    return v;
  endfunction

  function automatic sel_t mk(input method_t m, input mode_t md);
    sel_t r;
    r.valid  = 1'b1;
    r.method = m;
    r.mode   = md;
    return r;
  endfunction

  function automatic sel_t decode(input logic [SET_W-1:0] code, input logic mc);
    sel_t r;
    r = '{valid: 1'b0, method: M_VF, mode: MD_SPEED};
    unique case (code)
      CM_ENC_SPEED:   r = mk(M_ENC, MD_SPEED);
      CM_ENC_TORQUE:  r = mk(M_ENC, MD_TORQUE);
      CM_ENC_SPD_TRQ: r = mk(M_ENC, mc ? MD_TORQUE : MD_SPEED);
      CM_ENC_POS:     r = mk(M_ENC, MD_POS);
      CM_ENC_SPD_POS: r = mk(M_ENC, mc ? MD_POS : MD_SPEED);
      CM_ENC_POS_TRQ: r = mk(M_ENC, mc ? MD_TORQUE : MD_POS);
      CM_TEST:        r = mk(M_TEST, MD_SPEED);
      CM_SLV_SPEED:   r = mk(M_SLV, MD_SPEED);
      CM_SLV_TORQUE:  r = mk(M_SLV, MD_TORQUE);
      CM_SLV_SPD_TRQ: r = mk(M_SLV, mc ? MD_TORQUE : MD_SPEED);
      CM_FLUX:        r = mk(M_FLUX, MD_SPEED);
      default:        r.valid = 1'b0;
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------
  // terminal mapping
  // ------------------------------------------------------------
  logic [N_TERM-1:0] hit_sec;
  logic [N_TERM-1:0] hit_fb;
  logic [N_TERM-1:0] hit_mc;
  logic [N_TERM-1:0] map_sec;
  logic [N_TERM-1:0] map_fb;
  logic [N_TERM-1:0] map_mc;

  for (genvar i = 0; i < N_TERM; i++) begin : g_term
    assign map_sec[i] = s_r.input_terminal_function_settings[i] == FUNC_SECOND;
    assign map_fb[i]  = s_r.input_terminal_function_settings[i] == FUNC_VF_FB;
    assign map_mc[i]  = s_r.input_terminal_function_settings[i] == FUNC_MODE_SW;
    assign hit_sec[i] = map_sec[i] & terminal_in[i];
    assign hit_fb[i]  = map_fb[i] & terminal_in[i];
    assign hit_mc[i]  = map_mc[i] & terminal_in[i];
  end

  logic second_function_input;
  logic vf_fallback_input;
  logic mode_switch_input;
  logic fb_mapped;
  logic fb_poles;

  assign second_function_input = (|map_sec) ? (|hit_sec) : second_function_pin;
  assign vf_fallback_input     = |hit_fb;
  assign mode_switch_input     = |hit_mc;
  assign fb_mapped             = |map_fb;
  assign fb_poles = s_r.pole_count_setting inside {POLE_FB_12, POLE_FB_14, POLE_FB_16,
                                                   POLE_FB_18, POLE_FB_20};

  // ------------------------------------------------------------
  // method selection
  // ------------------------------------------------------------
  sel_t first_sel;
  sel_t target;

  always_comb begin
    sel_t second_sel;
    second_sel = '{valid: 1'b0, method: M_VF, mode: MD_SPEED};
    if (s_r.motor_capacity_setting == CODE_NONE || s_r.pole_count_setting == CODE_NONE) begin
      first_sel = mk(M_VF, MD_SPEED);
    end else begin
      first_sel = decode(s_r.control_method_code, mode_switch_input);
    end
    if (s_r.second_motor_type_setting == CODE_NONE) begin
      second_sel = first_sel;
      if (!fb_mapped && fb_poles) begin
        second_sel = mk(M_VF, MD_SPEED);
      end
    end else if (s_r.second_motor_capacity_setting == CODE_NONE ||
                 s_r.second_motor_pole_setting == CODE_NONE) begin
      second_sel = mk(M_VF, MD_SPEED);
    end else if (s_r.second_control_method_code == CODE_NONE ||
                 s_r.second_control_method_code == CM_FLUX) begin
      second_sel = mk(M_FLUX, MD_SPEED);
    end else if (s_r.second_control_method_code inside
                 {CM_SLV_SPEED, CM_SLV_TORQUE, CM_SLV_SPD_TRQ}) begin
      second_sel = decode(s_r.second_control_method_code, mode_switch_input);
    end
    target = second_function_input ? second_sel : first_sel;
    if (fb_poles && vf_fallback_input && target.valid) begin
      target = mk(M_VF, MD_SPEED);
    end
    if (!target.valid) begin
      target = s_r.want;
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic       hit;
  logic [3:0] be;
  logic       pos_change;
  logic       low_speed;

  assign hit = (avs_read | avs_write) & ~s_r.waitreq;
  assign be  = avs_byteenable;
  assign pos_change = (target.mode == MD_POS) != (s_r.out.mode == MD_POS);
  assign low_speed  = output_freq <= s_r.low_speed_threshold_setting;

  always_comb begin
    logic [3:0] tix;
    tix   = 4'h0;
    s_nxt = s_r;

    // bus: one wait cycle, answer when waitrequest drops
    s_nxt.waitreq = 1'b1;
    s_nxt.rdata   = 32'h0000_0000;
    if ((avs_read | avs_write) && s_r.waitreq) begin
      s_nxt.waitreq = 1'b0;
      if (avs_read) begin
        unique case (avs_address)
          REG_CTRL_METHOD: s_nxt.rdata[SET_W-1:0] = s_r.control_method_code;
          REG_MOTOR_CAP:   s_nxt.rdata[SET_W-1:0] = s_r.motor_capacity_setting;
          REG_POLE_COUNT:  s_nxt.rdata[SET_W-1:0] = s_r.pole_count_setting;
          REG_SEC_TYPE:    s_nxt.rdata[SET_W-1:0] = s_r.second_motor_type_setting;
          REG_SEC_METHOD:  s_nxt.rdata[SET_W-1:0] = s_r.second_control_method_code;
          REG_SEC_CAP:     s_nxt.rdata[SET_W-1:0] = s_r.second_motor_capacity_setting;
          REG_SEC_POLE:    s_nxt.rdata[SET_W-1:0] = s_r.second_motor_pole_setting;
          REG_INERTIA:     s_nxt.rdata[SET_W-1:0] = s_r.load_inertia_ratio_setting;
          REG_LOW_SPEED:   s_nxt.rdata[SET_W-1:0] = s_r.low_speed_threshold_setting;
          REG_SPEED_CMD:   s_nxt.rdata[SPEED_W-1:0] = s_r.speed_cmd;
          REG_STATUS:      s_nxt.rdata[13:0] = {s_r.st, s_r.want.valid, s_r.want.method,
                                                s_r.want.mode, s_r.out.method, s_r.out.mode};
          REG_SIM_SPEED:   s_nxt.rdata[SPEED_W-1:0] = s_r.sim_speed;
          default: begin
            if (avs_address >= REG_TERM_BASE && avs_address <= REG_TERM_LAST) begin
              tix = 4'(avs_address[5:2] - REG_TERM_BASE[5:2]);
              s_nxt.rdata[FUNC_W-1:0] = s_r.input_terminal_function_settings[tix];
            end
          end
        endcase
      end
    end
    if (avs_write && hit) begin
      unique case (avs_address)
        REG_CTRL_METHOD: s_nxt.control_method_code =
                           lanes(s_r.control_method_code, avs_writedata, be);
        REG_MOTOR_CAP:   s_nxt.motor_capacity_setting =
                           lanes(s_r.motor_capacity_setting, avs_writedata, be);
        REG_POLE_COUNT:  s_nxt.pole_count_setting =
                           lanes(s_r.pole_count_setting, avs_writedata, be);
        REG_SEC_TYPE:    s_nxt.second_motor_type_setting =
                           lanes(s_r.second_motor_type_setting, avs_writedata, be);
        REG_SEC_METHOD:  s_nxt.second_control_method_code =
                           lanes(s_r.second_control_method_code, avs_writedata, be);
        REG_SEC_CAP:     s_nxt.second_motor_capacity_setting =
                           lanes(s_r.second_motor_capacity_setting, avs_writedata, be);
        REG_SEC_POLE:    s_nxt.second_motor_pole_setting =
                           lanes(s_r.second_motor_pole_setting, avs_writedata, be);
        REG_INERTIA:     s_nxt.load_inertia_ratio_setting =
                           lanes(s_r.load_inertia_ratio_setting, avs_writedata, be);
        REG_LOW_SPEED:   s_nxt.low_speed_threshold_setting =
                           lanes(s_r.low_speed_threshold_setting, avs_writedata, be);
        REG_SPEED_CMD:   s_nxt.speed_cmd = lanes(s_r.speed_cmd, avs_writedata, be);
        default: begin
          // read-only and unmapped words swallow the write
          if (avs_address >= REG_TERM_BASE && avs_address <= REG_TERM_LAST && be[0]) begin
            tix = 4'(avs_address[5:2] - REG_TERM_BASE[5:2]);
            s_nxt.input_terminal_function_settings[tix] = avs_writedata[FUNC_W-1:0];
          end
        end
      endcase
    end

    // apply selection
    s_nxt.want = target;
    if (target.method != s_r.out.method) begin
      if (drive_running) begin
        s_nxt.st = ST_WAIT_STOP;
      end else begin
        s_nxt.st         = ST_STEADY;
        s_nxt.out.method = target.method;
        s_nxt.out.mode   = target.mode;
      end
    end else if (target.mode != s_r.out.mode) begin
      if (pos_change && drive_running && !low_speed) begin
        s_nxt.st = ST_WAIT_LOW;
      end else begin
        s_nxt.st       = ST_STEADY;
        s_nxt.out.mode = target.mode;
      end
    end else begin
      s_nxt.st = ST_STEADY;
    end

    // test operation drives nothing real
    s_nxt.out.test_active      = s_nxt.out.method == M_TEST;
    s_nxt.out.current_sense_en = s_nxt.out.method != M_TEST;
    s_nxt.out.voltage_out_en   = s_nxt.out.method != M_TEST;
    s_nxt.out.status_out_en    = s_nxt.out.method != M_TEST;

    // simulated speed: one step per (inertia + 1) cycles, heavier load ramps slower
    if (s_r.out.method == M_TEST) begin
      if (s_r.slope_cnt >= s_r.load_inertia_ratio_setting) begin
        s_nxt.slope_cnt = '0;
        if (s_r.sim_speed < s_r.speed_cmd) begin
          s_nxt.sim_speed = s_r.sim_speed + 1'b1;
        end else if (s_r.sim_speed > s_r.speed_cmd) begin
          s_nxt.sim_speed = s_r.sim_speed - 1'b1;
        end
      end else begin
        s_nxt.slope_cnt = s_r.slope_cnt + 1'b1;
      end
      s_nxt.mon = s_r.sim_speed;
    end else begin
      s_nxt.slope_cnt = '0;
      s_nxt.sim_speed = '0;
      s_nxt.mon       = output_freq;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.control_method_code              <= RST_CTRL_METHOD;
      s_r.motor_capacity_setting           <= CODE_NONE;
      s_r.pole_count_setting               <= CODE_NONE;
      s_r.second_motor_type_setting        <= CODE_NONE;
      s_r.second_control_method_code       <= CODE_NONE;
      s_r.second_motor_capacity_setting    <= CODE_NONE;
      s_r.second_motor_pole_setting        <= CODE_NONE;
      s_r.load_inertia_ratio_setting       <= RST_INERTIA;
      s_r.low_speed_threshold_setting      <= RST_LOW_SPEED;
      s_r.input_terminal_function_settings <= {N_TERM{FUNC_RESET}};
      s_r.st                               <= ST_STEADY;
      s_r.want                             <= '{valid: 1'b1, method: M_VF, mode: MD_SPEED};
      s_r.out.method                       <= M_VF;
      s_r.out.mode                         <= MD_SPEED;
      s_r.out.current_sense_en             <= 1'b1;
      s_r.out.voltage_out_en               <= 1'b1;
      s_r.out.status_out_en                <= 1'b1;
      s_r.waitreq                          <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata          = s_r.rdata;
  assign avs_waitrequest       = s_r.waitreq;
  assign ctrl_out              = s_r.out;
  assign pulse_monitor_output  = s_r.mon;
  assign analog_monitor_output = s_r.mon;

endmodule

/* logic/drive_mode_pkg.sv */
package drive_mode_pkg;

  // ------------------------------------------------------------
  // setting codes
  // ------------------------------------------------------------
  localparam int SET_W = 16;
  localparam logic [SET_W-1:0] CODE_NONE       = 16'h270f;
  localparam logic [SET_W-1:0] CM_ENC_SPEED    = 16'h0000;
  localparam logic [SET_W-1:0] CM_ENC_TORQUE   = 16'h0001;
  localparam logic [SET_W-1:0] CM_ENC_SPD_TRQ  = 16'h0002;
  localparam logic [SET_W-1:0] CM_ENC_POS      = 16'h0003;
  localparam logic [SET_W-1:0] CM_ENC_SPD_POS  = 16'h0004;
  localparam logic [SET_W-1:0] CM_ENC_POS_TRQ  = 16'h0005;
  localparam logic [SET_W-1:0] CM_TEST         = 16'h0009;
  localparam logic [SET_W-1:0] CM_SLV_SPEED    = 16'h000a;
  localparam logic [SET_W-1:0] CM_SLV_TORQUE   = 16'h000b;
  localparam logic [SET_W-1:0] CM_SLV_SPD_TRQ  = 16'h000c;
  localparam logic [SET_W-1:0] CM_FLUX         = 16'h0014;
  localparam logic [SET_W-1:0] POLE_FB_12      = 16'h000c;
  localparam logic [SET_W-1:0] POLE_FB_14      = 16'h000e;
  localparam logic [SET_W-1:0] POLE_FB_16      = 16'h0010;
  localparam logic [SET_W-1:0] POLE_FB_18      = 16'h0012;
  localparam logic [SET_W-1:0] POLE_FB_20      = 16'h0014;

  // ------------------------------------------------------------
  // input terminal function codes
  // ------------------------------------------------------------
  localparam int FUNC_W = 8;
  localparam logic [FUNC_W-1:0] FUNC_SECOND   = 8'h03;
  localparam logic [FUNC_W-1:0] FUNC_VF_FB    = 8'h12;
  localparam logic [FUNC_W-1:0] FUNC_MODE_SW  = 8'h1a;
  localparam logic [FUNC_W-1:0] FUNC_RESET    = 8'hff;
  localparam int N_TERM = 12;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL_METHOD   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MOTOR_CAP     = 8'h04;
  localparam logic [ADDR_W-1:0] REG_POLE_COUNT    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SEC_TYPE      = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_SEC_METHOD    = 8'h10;
  localparam logic [ADDR_W-1:0] REG_SEC_CAP       = 8'h14;
  localparam logic [ADDR_W-1:0] REG_SEC_POLE      = 8'h18;
  localparam logic [ADDR_W-1:0] REG_INERTIA       = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_LOW_SPEED     = 8'h20;
  localparam logic [ADDR_W-1:0] REG_SPEED_CMD     = 8'h24;
  localparam logic [ADDR_W-1:0] REG_STATUS        = 8'h28;
  localparam logic [ADDR_W-1:0] REG_SIM_SPEED     = 8'h2c;
  localparam logic [ADDR_W-1:0] REG_TERM_BASE     = 8'h40;
  localparam logic [ADDR_W-1:0] REG_TERM_LAST     = 8'h6c;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [SET_W-1:0] RST_CTRL_METHOD = CM_FLUX;
  localparam logic [SET_W-1:0] RST_INERTIA     = 16'h0007;
  localparam logic [SET_W-1:0] RST_LOW_SPEED   = 16'h0032;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    M_VF   = 3'h0,
    M_FLUX = 3'h1,
    M_SLV  = 3'h2,
    M_ENC  = 3'h3,
    M_TEST = 3'h4
  } method_t;

  typedef enum logic [1:0] {
    MD_SPEED  = 2'h0,
    MD_TORQUE = 2'h1,
    MD_POS    = 2'h2
  } mode_t;

  typedef enum logic [2:0] {
    ST_STEADY    = 3'b001,
    ST_WAIT_STOP = 3'b010,
    ST_WAIT_LOW  = 3'b100
  } apply_state_t;

  typedef struct packed {
    logic    valid;
    method_t method;
    mode_t   mode;
  } sel_t;

  typedef struct packed {
    method_t method;
    mode_t   mode;
    logic    test_active;
    logic    current_sense_en;
    logic    voltage_out_en;
    logic    status_out_en;
  } ctrl_out_t;

endpackage

/* verification/drive_control_mode_selector_checker.sv */
`timescale 1ns/10ps
module drive_control_mode_selector_checker
  import drive_mode_pkg::*;
#(parameter int SPEED_W = 16) (
  input wire logic               mclk,
  input wire logic               sys_rst,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest,
  input wire logic               drive_running,
  input wire logic [SPEED_W-1:0] output_freq,
  input wire ctrl_out_t          ctrl_out
);
  // ------
  // port checks
  // ------
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  AST_ACK: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_RD_IDLE: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("stale read data");
  AST_TEST_OFF: assert property (ctrl_out.test_active |-> !ctrl_out.current_sense_en &&
    !ctrl_out.voltage_out_en && !ctrl_out.status_out_en) else $error("test enables on");
  AST_TEST_SPD: assert property (ctrl_out.test_active |-> ctrl_out.mode == MD_SPEED)
    else $error("test not speed");
  AST_FLUX_SPD: assert property (ctrl_out.method == M_FLUX |-> ctrl_out.mode == MD_SPEED)
    else $error("flux not speed");
  AST_SLV_NOPOS: assert property (ctrl_out.method == M_SLV |-> ctrl_out.mode != MD_POS)
    else $error("sensorless in position");
  AST_RUN_HOLD: assert property ($past(drive_running) |-> $stable(ctrl_out.method))
    else $error("method changed while running");
  AST_POS_LOW: assert property (drive_running && output_freq > RST_LOW_SPEED |=>
    (ctrl_out.mode == MD_POS) == ($past(ctrl_out.mode) == MD_POS)) else $error("early pos");
endmodule
bind drive_control_mode_selector drive_control_mode_selector_checker #(.SPEED_W(SPEED_W)) chk (
  .mclk(mclk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .drive_running(drive_running), .output_freq(output_freq), .ctrl_out(ctrl_out));

/* verification/drive_control_mode_selector_tb.sv */
`timescale 1ns/10ps
module drive_control_mode_selector_tb
  import drive_mode_pkg::*;
;
  logic        mclk, sys_rst, rd, wr, sfp, run_cmd, wreq, running;
  logic [7:0]  adr;
  logic [31:0] wd, rdata;
  logic [11:0] term;
  logic [15:0] fset, ofreq, pm, am;
  ctrl_out_t   co;
  int          num_errors, total_checks;
  drive_control_mode_selector drive_control_mode_selector_inst (.mclk(mclk), .sys_rst(sys_rst),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .terminal_in(term), .second_function_pin(sfp),
    .drive_running(running), .output_freq(ofreq), .ctrl_out(co), .pulse_monitor_output(pm),
    .analog_monitor_output(am));
  motor_core_model motor_core_model_inst (.mclk(mclk), .run_cmd(run_cmd), .freq_set(fset),
    .drive_running(running), .output_freq(ofreq));
  // ------
  // shared tasks
  // ------
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    adr <= a;
    wd <= {16'h0, d};
    wr <= w;
    rd <= !w;
    @(posedge mclk);
    while (wreq !== 1'b0 && n < 50) begin
      n++;
      @(posedge mclk);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 50) begin
      num_errors++;
      end_of_test;
    end
    // idle edge so the next call never re-raises a strobe in this step
    @(posedge mclk);
  endtask
  task automatic w(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic sk(input logic [2:0] m, input logic [1:0] md);
    cyc(3);
    chk("method_mode", {27'h0, m, md}, {27'h0, co.method, co.mode});
  endtask
  task automatic sel(input logic [15:0] c, input logic s, input logic [2:0] m, input logic [1:0] md);
    term[0] <= s;
    w(REG_CTRL_METHOD, c);
    sk(m, md);
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_reg;
    logic [31:0] q;
    bus(1'b0, REG_CTRL_METHOD, 16'h0, q);
    chk("method_reg", 32'h14, q);
    bus(1'b0, 8'h30, 16'h0, q);
    chk("unmapped", 32'h0, q);
    sk(M_VF, MD_SPEED);
    w(REG_MOTOR_CAP, 16'h000f);
    w(REG_POLE_COUNT, 16'h0004);
    w(REG_TERM_BASE, {8'h0, FUNC_MODE_SW});
    sk(M_FLUX, MD_SPEED);
    w(REG_MOTOR_CAP, CODE_NONE);
    sk(M_VF, MD_SPEED);
    w(REG_MOTOR_CAP, 16'h000f);
    $display("t_reg done");
  endtask
  task automatic t_sel;
    sel(16'h0, 1'b0, M_ENC, MD_SPEED);
    sel(16'h1, 1'b0, M_ENC, MD_TORQUE);
    sel(16'h3, 1'b0, M_ENC, MD_POS);
    sel(16'h2, 1'b1, M_ENC, MD_TORQUE);
    sel(16'h2, 1'b0, M_ENC, MD_SPEED);
    sel(16'h4, 1'b1, M_ENC, MD_POS);
    sel(16'h5, 1'b1, M_ENC, MD_TORQUE);
    sel(16'h5, 1'b0, M_ENC, MD_POS);
    sel(16'ha, 1'b0, M_SLV, MD_SPEED);
    sel(16'hb, 1'b0, M_SLV, MD_TORQUE);
    sel(16'hc, 1'b1, M_SLV, MD_TORQUE);
    sel(16'h7, 1'b1, M_SLV, MD_TORQUE);
    sel(16'h14, 1'b0, M_FLUX, MD_SPEED);
    $display("t_sel done");
  endtask
  task automatic t_sec;
    w(REG_SEC_TYPE, 16'h0001);
    w(REG_SEC_METHOD, CM_SLV_SPEED);
    w(REG_SEC_CAP, 16'h0005);
    w(REG_SEC_POLE, 16'h0004);
    sfp <= 1'b1;
    sk(M_SLV, MD_SPEED);
    w(REG_SEC_CAP, CODE_NONE);
    sk(M_VF, MD_SPEED);
    sfp <= 1'b0;
    w(REG_TERM_BASE + 8'h08, {8'h0, FUNC_SECOND});
    term[2] <= 1'b1;
    sk(M_VF, MD_SPEED);
    term[2] <= 1'b0;
    w(REG_SEC_TYPE, CODE_NONE);
    w(REG_POLE_COUNT, POLE_FB_12);
    term[2] <= 1'b1;
    sk(M_VF, MD_SPEED);
    term[2] <= 1'b0;
    w(REG_TERM_BASE + 8'h04, {8'h0, FUNC_VF_FB});
    term[1] <= 1'b1;
    sk(M_VF, MD_SPEED);
    term[1] <= 1'b0;
    sk(M_FLUX, MD_SPEED);
    w(REG_POLE_COUNT, 16'h0004);
    $display("t_sec done");
  endtask
  task automatic t_run;
    sel(16'h4, 1'b0, M_ENC, MD_SPEED);
    run_cmd <= 1'b1;
    fset <= 16'd100;
    cyc(120);
    term[0] <= 1'b1;
    sk(M_ENC, MD_SPEED);
    fset <= 16'd40;
    cyc(70);
    sk(M_ENC, MD_POS);
    w(REG_CTRL_METHOD, CM_SLV_SPD_TRQ);
    term[0] <= 1'b0;
    sk(M_ENC, MD_POS);
    run_cmd <= 1'b0;
    cyc(60);
    sk(M_SLV, MD_SPEED);
    run_cmd <= 1'b1;
    cyc(60);
    term[0] <= 1'b1;
    sk(M_SLV, MD_TORQUE);
    run_cmd <= 1'b0;
    cyc(60);
    $display("t_run done");
  endtask
  task automatic t_test;
    logic [31:0] q;
    w(REG_SPEED_CMD, 16'h0040);
    w(REG_CTRL_METHOD, CM_TEST);
    cyc(83);
    chk("ramp", 32'h1, {31'h0, pm >= 16'd9 && pm <= 16'd11});
    chk("enables", 32'h8, {28'h0, co.test_active, co.current_sense_en, co.voltage_out_en,
        co.status_out_en});
    cyc(600);
    chk("pulse_mon", 32'h40, {16'h0, pm});
    chk("analog_mon", 32'h40, {16'h0, am});
    bus(1'b0, REG_SIM_SPEED, 16'h0, q);
    chk("sim_reg", 32'h40, q);
    $display("t_test done");
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    {sys_rst, rd, wr, sfp, run_cmd, adr, wd, term, fset} = {1'b1, 72'h0};
    num_errors = 0;
    total_checks = 0;
    cyc(16);
    sys_rst <= 1'b0;
    cyc(1);
    t_reg;
    t_sel;
    t_sec;
    t_run;
    t_test;
    end_of_test;
  end
endmodule

/* verification/motor_core_model.sv */
`timescale 1ns/10ps
module motor_core_model (
  input  wire logic        mclk,
  input  wire logic        run_cmd,
  input  wire logic [15:0] freq_set,
  output logic             drive_running,
  output logic [15:0]      output_freq
);
  // ------
  // shaft ramps a unit a cycle, so running only drops at rest
  // ------
  initial output_freq = 16'h0;
  assign drive_running = run_cmd || (output_freq != 16'h0);
  always @(posedge mclk)
    if (run_cmd && output_freq < freq_set) output_freq <= output_freq + 16'h1;
    else if (output_freq > (run_cmd ? freq_set : 16'h0)) output_freq <= output_freq - 16'h1;
endmodule
